// file: hw/period_timer_pkg.sv
// constants, register map and types of the period timer
package period_timer_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PERIPHERAL_FLAGS = 8'h0C;
   localparam logic [7:0] IDX_FLAG_MASK = 8'h0D;
   localparam logic [7:0] IDX_TIMER_COUNT = 8'h11;
   localparam logic [7:0] IDX_TIMER_CONTROL = 8'h12;
   localparam logic [7:0] IDX_PERIOD_LIMIT = 8'h13;
   localparam int ADDR_W = 8;
   localparam int REG_W = 8;
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_LIMIT = 8'hFF;
   localparam logic [7:0] CONTROL_WMASK = 8'h7F;
   localparam int MATCH_FLAG_BIT = 1;
   localparam int RUN_BIT = 2;
   localparam int PRE_LSB = 0;
   localparam int POST_LSB = 3;
   // instruction clock is oscillator divided by four
   localparam logic [1:0] QCLK_LAST = 2'h3;
   localparam logic [3:0] PRE_LAST_1 = 4'h0;
   localparam logic [3:0] PRE_LAST_4 = 4'h3;
   localparam logic [3:0] PRE_LAST_16 = 4'hF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECODEERROR = 2'h3;
   typedef logic [1:0] pre_sel_t;
   typedef logic [3:0] post_sel_t;
endpackage

// file: hw/scaler_if.sv
// link between the timer core and its two scalers
`timescale 1ns/1ps
`default_nettype none
interface scaler_if;
   import period_timer_pkg::*;
   logic clr;
   logic run;
   pre_sel_t pre_sel;
   logic tick;
   logic match;
   post_sel_t post_sel;
   logic post_done;
   modport core (output clr, run, pre_sel, match, post_sel,
      input tick, post_done);
   modport pre (input clr, run, pre_sel, output tick);
   modport post (input clr, match, post_sel, output post_done);
endinterface
`default_nettype wire

// file: hw/prescaler.sv
// instruction clock divider and 1/4/16 prescaler
`timescale 1ns/1ps
`default_nettype none
module prescaler
   import period_timer_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   scaler_if.pre sif
);
   typedef struct packed {
      logic [1:0] qcnt;
      logic [3:0] pcnt;
      logic tick;
   } pre_state_s;

   pre_state_s st_r;
   pre_state_s st_nxt;

   function automatic logic [3:0] pre_last(input pre_sel_t sel);
      case (sel)
         2'h0: pre_last = PRE_LAST_1;
         2'h1: pre_last = PRE_LAST_4;
         default: pre_last = PRE_LAST_16;
      endcase
   endfunction

   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (sif.clr) begin
         st_nxt.qcnt = 2'h0;
         st_nxt.pcnt = 4'h0;
      end else if (sif.run) begin
         st_nxt.qcnt = st_r.qcnt + 2'h1;
         if (st_r.qcnt == QCLK_LAST) begin
            if (st_r.pcnt >= pre_last(sif.pre_sel)) begin
               st_nxt.pcnt = 4'h0;
               st_nxt.tick = 1'b1;
            end else begin
               st_nxt.pcnt = st_r.pcnt + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sif.tick = st_r.tick;
endmodule
`default_nettype wire

// file: hw/postscaler.sv
// 4-bit postscaler on the period match
`timescale 1ns/1ps
`default_nettype none
module postscaler
   import period_timer_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   scaler_if.post sif
);
   typedef struct packed {
      logic [3:0] cnt;
      logic done;
   } post_state_s;

   post_state_s st_r;
   post_state_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (sif.clr) begin
         st_nxt.cnt = 4'h0;
      end else if (sif.match) begin
         if (st_r.cnt >= sif.post_sel) begin
            st_nxt.cnt = 4'h0;
            st_nxt.done = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sif.post_done = st_r.done;
endmodule
`default_nettype wire

// file: hw/period_timer.sv
// period timer with prescaler, postscaler and avalon-mm registers
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module period_timer
   import period_timer_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [3:0] byteenable_i,
   input wire logic [31:0] writedata_i,
   output logic [31:0] readdata_o,
   output logic [1:0] response_o,
   output logic waitrequest_o,
   output logic irq_o,
   output logic match_o
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [1:0] resp;
      logic [REG_W-1:0] count;
      logic [REG_W-1:0] limit;
      logic [REG_W-1:0] control;
      logic [REG_W-1:0] flags;
      logic [REG_W-1:0] mask;
      logic match;
   } core_state_s;

   core_state_s st_r;
   core_state_s st_nxt;
   scaler_if sif ();

   logic req;
   logic wr_go;
   logic lane0;
   logic [REG_W-1:0] wbyte;
   logic [7:0] idx;
   logic hit;
   logic [REG_W-1:0] rsel;
   logic wr_count;
   logic wr_control;

   prescaler u_pre (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .sif(sif.pre)
   );

   postscaler u_post (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .sif(sif.post)
   );

   // bus: one wait cycle, then the request is taken
   assign req = read_i | write_i;
   assign waitrequest_o = req & ~st_r.ack;
   assign wr_go = write_i & st_r.ack;
   assign lane0 = byteenable_i[0];
   assign wbyte = writedata_i[REG_W-1:0];
   assign idx = {2'h0, address_i[ADDR_W-1:2]};
   assign wr_count = wr_go & lane0 & (idx == IDX_TIMER_COUNT);
   assign wr_control = wr_go & lane0 & (idx == IDX_TIMER_CONTROL);

   always_comb begin
      hit = 1'b1;
      rsel = '0;
      case (idx)
         IDX_PERIPHERAL_FLAGS: rsel = st_r.flags;
         IDX_FLAG_MASK: rsel = st_r.mask;
         IDX_TIMER_COUNT: rsel = st_r.count;
         IDX_TIMER_CONTROL: rsel = st_r.control;
         IDX_PERIOD_LIMIT: rsel = st_r.limit;
         default: hit = 1'b0;
      endcase
   end

   // scaler clear on count or control write
   assign sif.clr = wr_count | wr_control;
   assign sif.run = st_r.control[RUN_BIT];
   assign sif.pre_sel = st_r.control[PRE_LSB +: 2];
   assign sif.post_sel = st_r.control[POST_LSB +: 4];
   assign sif.match = st_r.match;

   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = req & ~st_r.ack;
      st_nxt.match = 1'b0;
      if (req & ~st_r.ack) begin
         st_nxt.rdata = {24'h0, rsel};
         st_nxt.resp = hit ? RESP_OKAY : RESP_DECODEERROR;
      end
      // counting; a software write to the count takes priority
      if (sif.tick && !wr_count) begin
         if (st_r.count == st_r.limit) begin
            st_nxt.count = '0;
            st_nxt.match = 1'b1;
         end else begin
            st_nxt.count = st_r.count + 8'h01;
         end
      end
      if (wr_go && lane0) begin
         case (idx)
            IDX_FLAG_MASK: st_nxt.mask = wbyte;
            IDX_TIMER_COUNT: st_nxt.count = wbyte;
            IDX_TIMER_CONTROL: st_nxt.control = wbyte & CONTROL_WMASK;
            IDX_PERIOD_LIMIT: st_nxt.limit = wbyte;
            IDX_PERIPHERAL_FLAGS: st_nxt.flags = st_r.flags & ~wbyte;
            default: st_nxt.limit = st_r.limit;
         endcase
      end
      // a postscaler completion wins over a clear in the same cycle
      if (sif.post_done) begin
         st_nxt.flags[MATCH_FLAG_BIT] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r.ack <= 1'b0;
         st_r.rdata <= '0;
         st_r.resp <= RESP_OKAY;
         st_r.count <= RST_COUNT;
         st_r.limit <= RST_LIMIT;
         st_r.control <= RST_CONTROL;
         st_r.flags <= RST_FLAGS;
         st_r.mask <= RST_MASK;
         st_r.match <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign readdata_o = st_r.rdata;
   assign response_o = st_r.resp;
   assign irq_o = |(st_r.flags & st_r.mask);
   assign match_o = st_r.match;
endmodule
`default_nettype wire

// file: tb/period_timer_asserts.sv
// port assertions for the period timer
`timescale 1ns/1ps
`default_nettype none
module period_timer_asserts
   import period_timer_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] readdata_o,
   input wire logic [1:0] response_o,
   input wire logic waitrequest_o,
   input wire logic irq_o,
   input wire logic match_o
);
   logic rq;
   logic rd_done;
   logic hit;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   assign rq = read_i || write_i;
   assign rd_done = read_i && !waitrequest_o;
   assign hit = address_i[7:2] inside {6'h0C, 6'h0D, [6'h11:6'h13]};
   wait_first_a: assert property (
      $rose(rq) |-> waitrequest_o) else $error("no wait");
   wait_one_a: assert property (
      rq && waitrequest_o |=> !waitrequest_o) else $error("wait");
   match_gap_a: assert property (
      match_o |=> !match_o [*3]) else $error("match");
   // flag sets two edges after the match pulse rises
   irq_rise_a: assert property (
      $rose(irq_o) |-> $past(match_o, 2) || $past(write_i))
      else $error("irq");
   irq_fall_a: assert property (
      $fell(irq_o) |-> $past(write_i)) else $error("irq");
   decode_err_a: assert property (
      rd_done && !hit |-> response_o == RESP_DECODEERROR &&
      readdata_o == 32'h0) else $error("unmapped");
   read_ok_a: assert property (
      rd_done && hit |-> response_o == RESP_OKAY &&
      readdata_o[31:8] == 24'h0) else $error("read");
   ctl_top_a: assert property (
      rd_done && address_i[7:2] == 6'h12 |-> !readdata_o[7]) else $error("ctl");
endmodule
bind period_timer period_timer_asserts chk (.ref_clk_i, .rst_i, .address_i,
   .read_i, .write_i, .readdata_o, .response_o, .waitrequest_o, .irq_o,
   .match_o);
`default_nettype wire

// file: tb/period_timer_tb.sv
// self-checking bench for the period timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
err_total++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module period_timer_tb
   import period_timer_pkg::*;
;
   logic ref_clk_i = 1'h0, rst_i = 1'h1, read_i = 1'h0, write_i = 1'h0;
   logic [ADDR_W-1:0] address_i = 8'h0;
   logic [3:0] byteenable_i = 4'hF;
   logic [31:0] writedata_i = 32'h0, readdata_o, q;
   logic [1:0] response_o, rs;
   logic waitrequest_o, irq_o, match_o;
   logic [3:0] pv [3] = '{4'h0, 4'h3, 4'hF};
   int err_total = 0, checks_done = 0, n, g, k, e;
   always #10 ref_clk_i = ~ref_clk_i;
   period_timer uut (.ref_clk_i, .rst_i, .address_i, .read_i, .write_i,
      .byteenable_i, .writedata_i, .readdata_o, .response_o,
      .waitrequest_o, .irq_o, .match_o);
   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // waits for a match pulse (m) or the end of bus wait (!m)
   task automatic till(input logic m, output int c);
      c = 0;
      do begin
         @(negedge ref_clk_i);
         c++;
      end while ((m ? match_o : !waitrequest_o) !== 1'h1 && c < 3000);
      if (c >= 3000) begin
         err_total++;
         complete_run();
      end
   endtask
   // request held until the rising edge that sees waitrequest low
   task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
      int c;
      @(posedge ref_clk_i);
      address_i <= {a, 2'h0};
      read_i <= !w;
      write_i <= w;
      writedata_i <= {24'h0, d};
      c = 0;
      do begin
         @(posedge ref_clk_i);
         c++;
      end while (waitrequest_o !== 1'h0 && c < 3000);
      if (c >= 3000) begin
         err_total++;
         complete_run();
      end else begin
         q = readdata_o;
         rs = response_o;
         read_i <= 1'h0;
         write_i <= 1'h0;
      end
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] x);
      acc(1'h0, a, 8'h0);
      `CHK("readdata", {24'h0, x}, q)
   endtask
   task automatic ci(input logic x);
      @(negedge ref_clk_i);
      `CHK("irq", x, irq_o)
   endtask
   initial begin
      repeat (10) @(posedge ref_clk_i);
      rst_i <= 1'h0;
      rd(6'h0C, 8'h00);
      rd(6'h0D, 8'h00);
      rd(6'h11, 8'h00);
      rd(6'h12, 8'h00);
      rd(6'h13, 8'hFF);
      rd(6'h00, 8'h00);
      `CHK("response", RESP_DECODEERROR, rs)
      acc(1'h1, 6'h13, 8'h5A);
      byteenable_i <= 4'h0;
      acc(1'h1, 6'h13, 8'hA5);
      byteenable_i <= 4'hF;
      rd(6'h13, 8'h5A);
      `CHK("response", RESP_OKAY, rs)
      acc(1'h1, 6'h11, 8'h37);
      acc(1'h1, 6'h12, 8'hFB);
      rd(6'h12, 8'h7B);
      repeat (200) @(posedge ref_clk_i);
      rd(6'h11, 8'h37);
      $display("access test done");
      acc(1'h1, 6'h13, 8'h02);
      acc(1'h1, 6'h11, 8'h00);
      for (int s = 0; s < 4; s++) begin
         acc(1'h1, 6'h12, 8'h04 | 8'(s));
         till(1'h1, n);
         till(1'h1, g);
         e = 12 * (s == 0 ? 1 : s == 1 ? 4 : 16);
         `CHK("period", e, g)
      end
      acc(1'h1, 6'h13, 8'h00);
      acc(1'h1, 6'h11, 8'h00);
      acc(1'h1, 6'h12, 8'h05);
      till(1'h1, n);
      repeat (5) @(posedge ref_clk_i);
      acc(1'h1, 6'h11, 8'h00);
      till(1'h1, g);
      `CHK("restart", n, g)
      $display("period test done");
      acc(1'h1, 6'h0D, 8'h02);
      foreach (pv[i]) begin
         acc(1'h1, 6'h12, 8'h00);
         acc(1'h1, 6'h0C, 8'h02);
         acc(1'h1, 6'h12, {1'h0, pv[i], 3'h4});
         n = 0;
         for (k = 0; k < 300 && irq_o !== 1'h1; k++) begin
            @(negedge ref_clk_i);
            if (match_o === 1'h1) n++;
         end
         if (k >= 300) begin
            err_total++;
            complete_run();
         end else `CHK("postscale", pv[i] + 1, n)
      end
      acc(1'h1, 6'h12, 8'h00);
      ci(1'h1);
      acc(1'h1, 6'h0D, 8'h00);
      ci(1'h0);
      rd(6'h0C, 8'h02);
      acc(1'h1, 6'h0D, 8'h02);
      ci(1'h1);
      acc(1'h1, 6'h0C, 8'h02);
      ci(1'h0);
      $display("irq test done");
      // second reset in mid-run
      acc(1'h1, 6'h11, 8'h37);
      acc(1'h1, 6'h13, 8'h5A);
      acc(1'h1, 6'h12, 8'h2D);
      rst_i <= 1'h1;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'h0;
      rd(6'h11, 8'h00);
      rd(6'h13, 8'hFF);
      rd(6'h12, 8'h00);
      rd(6'h0D, 8'h00);
      $display("reset test done");
      complete_run();
   end
endmodule
`default_nettype wire
